// [msh_cfg.svh]
// Offsets, field positions, reset values and counts of the mode and supply control bank.
`ifndef MSH_CFG_SVH
`define MSH_CFG_SVH

`define MSH_MSC_ADDR      7'h01
`define MSH_HWC_ADDR      7'h02

`define MSH_MODE_HI       7
`define MSH_MODE_LO       6
`define MSH_AUX_HI        4
`define MSH_AUX_LO        3
`define MSH_OVR_BIT       2
`define MSH_RT_HI         1
`define MSH_RT_LO         0

`define MSH_SRR_BIT       6
`define MSH_FOSW_BIT      5
`define MSH_CP_BIT        2
`define MSH_WDC_BIT       0

`define MSH_MSC_RESET     8'h00
`define MSH_MSC_WMASK     8'hdf
`define MSH_MSC_RST_KEEP  8'h03
`define MSH_HWC_RESET     8'h00
`define MSH_HWC_WMASK     8'h65
`define MSH_HWC_RST_KEEP  8'h45
`define MSH_STATUS_BYTE   8'h00

`define MSH_AUX_OFF       2'h0
`define MSH_AUX_DEV       2'h3

`define MSH_FRAME_BITS    5'h10
`define MSH_BYTE_BITS     5'h08

`endif

// [msh_pkg.sv]
// Types shared by the mode and supply control bank and its testbench.
package msh_pkg;

  typedef enum logic [1:0] {
    MSH_MODE_NORMAL = 2'b00,
    MSH_MODE_SLEEP  = 2'b01,
    MSH_MODE_STOP   = 2'b10,
    MSH_MODE_SOFT   = 2'b11
  } msh_mode_type;

  typedef enum logic [1:0] {
    MSH_SPI_IDLE  = 2'b00,
    MSH_SPI_SHIFT = 2'b01
  } msh_spi_state_type;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } msh_frame_type;

  typedef struct packed {
    logic restart_enter;
    logic overtemp;
    logic main_ov;
    logic failure_active;
    logic fo_configured;
    logic lock_zero;
    logic lock_one;
    logic dev_mode;
  } msh_event_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] aux_regulator_mode;
    logic       main_overvoltage_reaction;
    logic [1:0] main_reset_threshold_sel;
    logic       soft_reset_pin_keep;
    logic       failure_output_sw_activate;
    logic       charge_pump_enable;
    logic       watchdog_fail_count_sel;
  } msh_ctrl_type;

endpackage

// [msh_regs.sv]
// Mode and supply control plus hardware control register pair behind an SPI slave.
`timescale 1ns/1ps
`default_nettype none
`include "msh_cfg.svh"

// What this block does
// - Mode field: normal, sleep, stop, soft reset.
// - Auxiliary regulator mode field with four settings.
// - Overvoltage always flags; restart only if enabled.
// - Reset threshold select, 00 is highest.
// - No stop to sleep transition over SPI.
// - Stop to normal ignores bits 4:0, flags.
// - Restart forces mode field to normal.
// - Restart or overtemperature turns auxiliary regulator off.
// - Write returns previously programmed contents.
// - Development mode: auxiliary powers up on, soft reset off.
// - Mode register resets zero; restart keeps threshold.
// - Bit 6 chooses reset pin pulse on soft reset.
// - Failure output by failures or, when configured, software bit.
// - Bit 2 enables charge pump, lockable.
// - Bit 0 picks first or second watchdog failure.
// - Restart clears software failure output activation.
// - Soft reset spares locked lockable bits.
// - Hardware register reset and restart values.
// - Reserved bits always read zero.
// - Locked bits ignore writes.
module msh_regs (
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // SPI pins, sampled in the system clock
  input  wire logic              spi_sck_in,
  input  wire logic              spi_cs_b_in,
  input  wire logic              spi_mosi_in,
  output logic                   spi_miso_out,
  output logic                   spi_miso_oe_out,
  // Hardware events and levels
  input  wire msh_pkg::msh_event_type evt_in,
  // Control outputs
  output msh_pkg::msh_ctrl_type  ctrl_out,
  output logic                   main_overvoltage_flag_out,
  output logic                   ov_restart_req_out,
  output logic                   failure_output_out,
  output logic                   soft_reset_out,
  output logic                   reset_output_pin_pulse_out,
  output logic                   spi_fail_out
);
  import msh_pkg::*;

  // Reserved positions are masked so they always read zero.
  // Unmapped addresses answer zero as well.
  function automatic logic [7:0] read_byte(input logic [6:0] addr,
                                           input logic [7:0] msc,
                                           input logic [7:0] hwc);
    logic [7:0] val;
    val = 8'h00;
    if (addr == `MSH_MSC_ADDR) begin
      val = msc & `MSH_MSC_WMASK;
    end else if (addr == `MSH_HWC_ADDR) begin
      val = hwc & `MSH_HWC_WMASK;
    end
    return val;
  endfunction

  // Merges only the writable positions of a new byte into the old one.
  function automatic logic [7:0] merge(input logic [7:0] old_val,
                                       input logic [7:0] new_val,
                                       input logic [7:0] mask);
    return (old_val & ~mask) | (new_val & mask);
  endfunction

  // SPI front end state.
  msh_spi_state_type spi_state_reg;
  msh_spi_state_type spi_state_next;
  logic              sck_prev_reg;
  logic              sck_prev_next;
  logic [4:0]        bit_cnt_reg;
  logic [4:0]        bit_cnt_next;
  logic [15:0]       rx_reg;
  logic [15:0]       rx_next;
  logic [7:0]        tx_reg;
  logic [7:0]        tx_next;
  logic              miso_reg;
  logic              miso_next;
  logic              commit_reg;
  logic              commit_next;

  // Register bank state.
  logic [7:0]        msc_reg;
  logic [7:0]        msc_next;
  logic [7:0]        hwc_reg;
  logic [7:0]        hwc_next;
  logic              por_load_reg;
  logic              por_load_next;
  logic              ov_flag_reg;
  logic              ov_flag_next;
  logic              ov_req_reg;
  logic              ov_req_next;
  logic              soft_reg;
  logic              soft_next;
  logic              rst_pulse_reg;
  logic              rst_pulse_next;
  logic              spi_fail_reg;
  logic              spi_fail_next;
  logic              fo_reg;
  logic              fo_next;

  msh_frame_type     frame;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_active;

  assign cs_active = ~spi_cs_b_in;
  assign sck_rise  = spi_sck_in & ~sck_prev_reg;
  assign sck_fall  = ~spi_sck_in & sck_prev_reg;
  assign frame     = msh_frame_type'(rx_reg);

  // Sck is sampled with the system clock, so each of its phases must last at least
  // one clock; a shorter phase can slip between two samples and lose an edge.
  always_comb begin
    sck_prev_next = spi_sck_in;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_prev_next;
    end
  end

  // Mode 0 SPI: the host samples on rising edges, we change on falling ones.
  always_comb begin
    spi_state_next = spi_state_reg;
    bit_cnt_next   = bit_cnt_reg;
    rx_next        = rx_reg;
    tx_next        = tx_reg;
    miso_next      = miso_reg;
    commit_next    = 1'b0;
    case (spi_state_reg)
      MSH_SPI_IDLE: begin
        if (cs_active) begin
          spi_state_next = MSH_SPI_SHIFT;
          bit_cnt_next   = 5'h00;
          // Status bit 7 must stand before the first rise, so it goes out now.
          tx_next        = `MSH_STATUS_BYTE << 1;
          miso_next      = (`MSH_STATUS_BYTE & 8'h80) != 8'h00;
        end
      end
      MSH_SPI_SHIFT: begin
        if (!cs_active) begin
          spi_state_next = MSH_SPI_IDLE;
          // Any other count means a cut or overlong frame, which is dropped.
          commit_next    = (bit_cnt_reg == `MSH_FRAME_BITS);
        end else begin
          if (sck_rise) begin
            rx_next = {rx_reg[14:0], spi_mosi_in};
            // Counting stops one past a full frame, so an overlong frame never looks complete.
            if (bit_cnt_reg != `MSH_FRAME_BITS + 5'h01) begin
              bit_cnt_next = bit_cnt_reg + 5'h01;
            end
            // Contents are captured before any write of this frame lands.
            if (bit_cnt_reg == `MSH_BYTE_BITS - 5'h01) begin
              tx_next = read_byte(rx_next[6:0], msc_reg, hwc_reg);
            end
          end
          if (sck_fall) begin
            miso_next = tx_reg[7];
            tx_next   = {tx_reg[6:0], 1'b0};
          end
        end
      end
      default: begin
        spi_state_next = MSH_SPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      spi_state_reg <= MSH_SPI_IDLE;
      bit_cnt_reg   <= 5'h00;
      rx_reg        <= 16'h0000;
      tx_reg        <= 8'h00;
      miso_reg      <= 1'b0;
      commit_reg    <= 1'b0;
    end else begin
      spi_state_reg <= spi_state_next;
      bit_cnt_reg   <= bit_cnt_next;
      rx_reg        <= rx_next;
      tx_reg        <= tx_next;
      miso_reg      <= miso_next;
      commit_reg    <= commit_next;
    end
  end

  // Register bank. Priority: restart, then soft reset, then a host write.
  always_comb begin
    logic [7:0]   wr_val;
    logic [7:0]   wmask;
    msh_mode_type cur_mode;
    msh_mode_type req_mode;
    wr_val         = frame.data;
    wmask          = `MSH_HWC_WMASK;
    cur_mode       = msh_mode_type'(msc_reg[`MSH_MODE_HI:`MSH_MODE_LO]);
    req_mode       = msh_mode_type'(wr_val[`MSH_MODE_HI:`MSH_MODE_LO]);
    msc_next       = msc_reg;
    hwc_next       = hwc_reg;
    por_load_next  = 1'b0;
    soft_next      = 1'b0;
    rst_pulse_next = 1'b0;
    spi_fail_next  = 1'b0;

    // The development strap is caught on the first edge after reset release.
    if (por_load_reg && evt_in.dev_mode) begin
      msc_next[`MSH_AUX_HI:`MSH_AUX_LO] = `MSH_AUX_DEV;
    end

    // Restart keeps the threshold select and the configuration bits, nothing else.
    // A write committing in the same cycle is lost; the host reprograms after restart.
    if (evt_in.restart_enter) begin
      msc_next = msc_reg & `MSH_MSC_RST_KEEP;
      hwc_next = hwc_reg & `MSH_HWC_RST_KEEP;
    end else if (commit_reg && frame.wr) begin
      if (frame.addr == `MSH_MSC_ADDR) begin
        if (req_mode == MSH_MODE_SOFT) begin
          soft_next      = 1'b1;
          rst_pulse_next = ~hwc_reg[`MSH_SRR_BIT];
          // Development mode does not bring the auxiliary regulator back here.
          msc_next       = `MSH_MSC_RESET;
          hwc_next       = `MSH_HWC_RESET;
          if (evt_in.lock_one) begin
            hwc_next[`MSH_SRR_BIT] = hwc_reg[`MSH_SRR_BIT];
          end
          if (evt_in.lock_zero) begin
            hwc_next[`MSH_CP_BIT] = hwc_reg[`MSH_CP_BIT];
          end
        end else if (cur_mode == MSH_MODE_STOP && req_mode == MSH_MODE_SLEEP) begin
          // Only the mode change is refused; the other fields still take the write.
          msc_next = merge(msc_reg, wr_val, `MSH_MSC_WMASK);
          msc_next[`MSH_MODE_HI:`MSH_MODE_LO] = MSH_MODE_STOP;
        end else if (cur_mode == MSH_MODE_STOP && req_mode == MSH_MODE_NORMAL) begin
          msc_next = msc_reg;
          msc_next[`MSH_MODE_HI:`MSH_MODE_LO] = MSH_MODE_NORMAL;
          spi_fail_next = ((wr_val ^ msc_reg) & 8'h1f & `MSH_MSC_WMASK) != 8'h00;
        end else begin
          msc_next = merge(msc_reg, wr_val, `MSH_MSC_WMASK);
        end
      end else if (frame.addr == `MSH_HWC_ADDR) begin
        // Locked positions keep their value; the free ones in the same byte still take the write.
        if (evt_in.lock_one) begin
          wmask[`MSH_SRR_BIT] = 1'b0;
        end
        if (evt_in.lock_zero) begin
          wmask[`MSH_CP_BIT] = 1'b0;
        end
        hwc_next = merge(hwc_reg, wr_val, wmask);
      end
    end

    // Overtemperature acts on top of whatever else happened this cycle.
    if (evt_in.overtemp) begin
      msc_next[`MSH_AUX_HI:`MSH_AUX_LO] = `MSH_AUX_OFF;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      msc_reg       <= `MSH_MSC_RESET;
      hwc_reg       <= `MSH_HWC_RESET;
      por_load_reg  <= 1'b1;
      soft_reg      <= 1'b0;
      rst_pulse_reg <= 1'b0;
      spi_fail_reg  <= 1'b0;
    end else begin
      msc_reg       <= msc_next;
      hwc_reg       <= hwc_next;
      por_load_reg  <= por_load_next;
      soft_reg      <= soft_next;
      rst_pulse_reg <= rst_pulse_next;
      spi_fail_reg  <= spi_fail_next;
    end
  end

  // Overvoltage group. The flag is sticky and always set; only the restart request
  // depends on the reaction bit.
  always_comb begin
    ov_flag_next = ov_flag_reg | evt_in.main_ov;
    ov_req_next  = evt_in.main_ov & msc_reg[`MSH_OVR_BIT];
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ov_flag_reg <= 1'b0;
      ov_req_reg  <= 1'b0;
    end else begin
      ov_flag_reg <= ov_flag_next;
      ov_req_reg  <= ov_req_next;
    end
  end

  // Failure output group. It follows the software bit as it is about to be stored,
  // so a restart that clears the bit releases the output in the same cycle.
  always_comb begin
    // A failure holds the output regardless of the software bit.
    fo_next = evt_in.failure_active |
              (hwc_next[`MSH_FOSW_BIT] & evt_in.fo_configured);
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fo_reg <= 1'b0;
    end else begin
      fo_reg <= fo_next;
    end
  end

  // The overvoltage flag is sticky; its clearing belongs to the status bank.
  assign main_overvoltage_flag_out  = ov_flag_reg;
  assign ov_restart_req_out         = ov_req_reg;
  assign failure_output_out         = fo_reg;
  assign soft_reset_out             = soft_reg;
  assign reset_output_pin_pulse_out = rst_pulse_reg;
  assign spi_fail_out               = spi_fail_reg;
  // The enable drops with chip select itself rather than a clock later, so the host
  // never sees two drivers on a shared data line.
  assign spi_miso_out               = miso_reg;
  assign spi_miso_oe_out            = (spi_state_reg == MSH_SPI_SHIFT) & cs_active;

  // Field copies for the regulators, the mode logic and the watchdog outside this bank.
  always_comb begin
    ctrl_out.mode                       = msc_reg[`MSH_MODE_HI:`MSH_MODE_LO];
    ctrl_out.aux_regulator_mode         = msc_reg[`MSH_AUX_HI:`MSH_AUX_LO];
    ctrl_out.main_overvoltage_reaction  = msc_reg[`MSH_OVR_BIT];
    ctrl_out.main_reset_threshold_sel   = msc_reg[`MSH_RT_HI:`MSH_RT_LO];
    ctrl_out.soft_reset_pin_keep        = hwc_reg[`MSH_SRR_BIT];
    ctrl_out.failure_output_sw_activate = hwc_reg[`MSH_FOSW_BIT];
    ctrl_out.charge_pump_enable         = hwc_reg[`MSH_CP_BIT];
    ctrl_out.watchdog_fail_count_sel    = hwc_reg[`MSH_WDC_BIT];
  end

endmodule
`default_nettype wire

// [msh_regs_checker.sv]
// Concurrent checks on the outputs of the mode and supply control bank.
`timescale 1ns/1ps
`default_nettype none
module msh_regs_checker (
  // Clock and reset
  input wire logic                  mclk_in,
  input wire logic                  rst_b_in,
  // Watched ports
  input wire msh_pkg::msh_event_type evt_in,
  input wire msh_pkg::msh_ctrl_type  ctrl_out,
  input wire logic                  main_overvoltage_flag_out,
  input wire logic                  ov_restart_req_out,
  input wire logic                  failure_output_out,
  input wire logic                  soft_reset_out,
  input wire logic                  reset_output_pin_pulse_out,
  input wire logic                  spi_fail_out
);
  import msh_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence restart_seen;
    evt_in.restart_enter;
  endsequence
  sequence restart_done;
    ctrl_out.mode == 2'b00 && ctrl_out.aux_regulator_mode == 2'b00
      && !ctrl_out.failure_output_sw_activate && !ctrl_out.main_overvoltage_reaction;
  endsequence
  chk_ov_flag_sticky: assert property (evt_in.main_ov |=> main_overvoltage_flag_out [*3])
    else $error("overvoltage flag not set and held");
  chk_ov_restart_req: assert property (evt_in.main_ov |=>
    ov_restart_req_out == $past(ctrl_out.main_overvoltage_reaction))
    else $error("overvoltage restart request wrong");
  chk_restart_fields: assert property (restart_seen |=> restart_done)
    else $error("restart did not force mode, aux and software bit");
  chk_overtemp_aux: assert property (evt_in.overtemp |=> ctrl_out.aux_regulator_mode == 2'b00)
    else $error("overtemperature left aux regulator on");
  chk_fo_output_level: assert property (
    failure_output_out == ($past(evt_in.failure_active)
    | (ctrl_out.failure_output_sw_activate & $past(evt_in.fo_configured))))
    else $error("failure output level wrong");
  chk_srst_pin_pulse: assert property (soft_reset_out |->
    reset_output_pin_pulse_out == !$past(ctrl_out.soft_reset_pin_keep))
    else $error("reset pin pulse does not follow keep bit");
  chk_srst_values: assert property (soft_reset_out |-> ctrl_out.mode == 2'b00
    && ctrl_out.aux_regulator_mode == 2'b00 && ctrl_out.main_reset_threshold_sel == 2'b00
    && !ctrl_out.failure_output_sw_activate && !ctrl_out.watchdog_fail_count_sel)
    else $error("soft reset values wrong");
  chk_srst_lock_keep: assert property (soft_reset_out && evt_in.lock_one |->
    $stable(ctrl_out.soft_reset_pin_keep))
    else $error("locked keep bit changed by soft reset");
  chk_pulse_single: assert property ((soft_reset_out or spi_fail_out) |=>
    !soft_reset_out && !spi_fail_out)
    else $error("pulse longer than one cycle");
endmodule
bind msh_regs msh_regs_checker u_msh_regs_checker (.*);
`default_nettype wire

// [msh_host.sv]
// Host model acting as SPI master toward the control bank.
`timescale 1ns/1ps
`default_nettype none
module msh_host (
  // Clock
  input  wire logic mclk_in,
  // SPI pins
  output logic      spi_sck_out,
  output logic      spi_cs_b_out,
  output logic      spi_mosi_out,
  input  wire logic spi_miso_in
);
  initial begin
    spi_sck_out = 1'b0;
    spi_cs_b_out = 1'b1;
    spi_mosi_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Phases vary from three to five clocks since the bank samples sck with its own clock.
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
    int ph;
    ph = 3 + ($urandom % 3);
    rx = 8'h00;
    spi_cs_b_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi_out = tx[15 - i];
      tick(ph);
      spi_sck_out = 1'b1;
      if (i >= 8) rx = {rx[6:0], spi_miso_in};
      tick(ph);
      spi_sck_out = 1'b0;
    end
    tick(ph);
    spi_cs_b_out = 1'b1;
    spi_mosi_out = ~spi_mosi_out;
    tick(3);
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the mode and supply control bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import msh_pkg::*;
  logic          mclk_in, rst_b_in, sck, cs_b, mosi, miso, oe, miso_w;
  logic          ov_flag, ov_req, fo, srst, pin_pulse, spi_fail;
  logic [7:0]    m1, m2, rx;
  msh_event_type evt;
  msh_ctrl_type  ctrl;
  int            err_count, checks_done, fails, srsts, pulses;
  // Miso idles high when the bank lets go of it.
  assign miso_w = oe ? miso : 1'b1;
  msh_regs u_msh_regs (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .spi_sck_in(sck),
    .spi_cs_b_in(cs_b), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe),
    .evt_in(evt), .ctrl_out(ctrl), .main_overvoltage_flag_out(ov_flag),
    .ov_restart_req_out(ov_req), .failure_output_out(fo), .soft_reset_out(srst),
    .reset_output_pin_pulse_out(pin_pulse), .spi_fail_out(spi_fail));
  msh_host u_msh_host (.mclk_in(mclk_in), .spi_sck_out(sck), .spi_cs_b_out(cs_b),
    .spi_mosi_out(mosi), .spi_miso_in(miso_w));
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Pulses are counted away from the edge that launches them.
  always @(negedge mclk_in) begin
    if (spi_fail === 1'b1) fails++;
    if (srst === 1'b1) srsts++;
    if (pin_pulse === 1'b1) pulses++;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge mclk_in);
    #1;
  endtask
  function automatic logic [7:0] exp_msc(input logic [7:0] old, input logic [7:0] d);
    if (old[7:6] == 2'b10 && d[7:6] == 2'b01) return {2'b10, d[5:0]} & 8'hdf;
    if (old[7:6] == 2'b10 && d[7:6] == 2'b00) return {2'b00, old[5:0]};
    return d & 8'hdf;
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_msh_host.xfer({1'b1, a, d}, 16, rx);
    chk("write echo", rx, (a == 7'h01) ? m1 : m2);
    if (a == 7'h01) m1 = exp_msc(m1, d);
    else m2 = (m2 & {1'b0, evt.lock_one, 3'b000, evt.lock_zero, 2'b00})
      | (d & 8'h65 & ~{1'b0, evt.lock_one, 3'b000, evt.lock_zero, 2'b00});
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_msh_host.xfer({1'b0, a, 8'h00}, 16, rx);
    chk("read back", rx, e);
  endtask
  initial begin
    #1500000;
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'h864ec711));
    {err_count, checks_done, fails, srsts, pulses} = '0;
    evt = '0;
    evt.dev_mode = 1'b1;
    rst_b_in = 1'b0;
    m1 = 8'h18;
    m2 = 8'h00;
    repeat (6) @(posedge mclk_in);
    #1 rst_b_in = 1'b1;
    step();
    step();
    rd(7'h01, m1);
    rd(7'h05, 8'h00);
    wr(7'h01, 8'hc0);
    m1 = 8'h00;
    rd(7'h01, m1);
    for (int i = 0; i < 8; i++) begin
      wr(7'h01, 8'($urandom) & 8'h7f);
      wr(7'h02, 8'($urandom));
      rd(7'h01, m1);
      rd(7'h02, m2);
    end
    wr(7'h01, 8'h9a);
    wr(7'h01, 8'h41);
    rd(7'h01, m1);
    wr(7'h01, 8'h1f);
    rd(7'h01, m1);
    chk("stop exit flag", 8'(fails), 8'h01);
    wr(7'h01, 8'h1f);
    evt.overtemp = 1'b1;
    step();
    evt.overtemp = 1'b0;
    m1 = m1 & 8'he7;
    rd(7'h01, m1);
    evt.main_ov = 1'b1;
    step();
    evt.main_ov = 1'b0;
    chk("ov restart request", {7'h00, ov_req}, 8'h01);
    step();
    chk("ov flag", {7'h00, ov_flag}, 8'h01);
    evt.fo_configured = 1'b1;
    wr(7'h02, 8'h25);
    chk("failure output", {7'h00, fo}, 8'h01);
    evt.restart_enter = 1'b1;
    step();
    evt.restart_enter = 1'b0;
    m1 = m1 & 8'h03;
    m2 = m2 & 8'h45;
    step();
    chk("failure output", {7'h00, fo}, 8'h00);
    rd(7'h01, m1);
    rd(7'h02, m2);
    evt.main_ov = 1'b1;
    step();
    evt.main_ov = 1'b0;
    chk("ov restart request", {7'h00, ov_req}, 8'h00);
    evt.failure_active = 1'b1;
    wr(7'h02, 8'h25);
    wr(7'h02, 8'h05);
    chk("failure output", {7'h00, fo}, 8'h01);
    evt.failure_active = 1'b0;
    step();
    chk("failure output", {7'h00, fo}, 8'h00);
    wr(7'h02, 8'h45);
    evt.lock_one = 1'b1;
    evt.lock_zero = 1'b1;
    wr(7'h02, 8'h01);
    rd(7'h02, m2);
    wr(7'h01, 8'hc0);
    m1 = 8'h00;
    m2 = m2 & 8'h44;
    rd(7'h02, m2);
    chk("charge pump", {7'h00, ctrl.charge_pump_enable}, 8'h01);
    chk("mode out", {6'h00, ctrl.mode}, 8'h00);
    chk("soft resets", 8'(srsts), 8'h02);
    chk("reset pin pulses", 8'(pulses), 8'h01);
    u_msh_host.xfer({1'b1, 7'h01, 8'h03}, 15, rx);
    rd(7'h01, m1);
    summarize();
  end
endmodule
`default_nettype wire
